// ==== design/pim_top.v ====
/*
 * Peripheral interrupt enable masks with APB register access.
 * Two 8-bit enable registers gate seven peripheral interrupt requests,
 * and a global gate in the core control register overrides them all.
 * Sticky status, a write-one clear register and one level interrupt.
 *
 * Register map, one aligned 32-bit word each:
 *   0x00 second enable register: oscillator fail, clock switch, logic cells
 *   0x04 third enable register: waveform generator, capture/compare units
 *   0x08 core control, bit 0 is the global peripheral gate
 *   0x0C sticky status, read only, layout {third, second}
 *   0x10 clear, write one to clear a status bit, reads zero
 *   0x14 raw request levels, read only
 * Unmapped offsets answer with pslverr and read zero; such writes are dropped.
 * Writes to status or raw are ignored without an error.
 * The enable registers double as the masks of the sticky status toward irq.
 * A status bit is set by the request level; a set beats a clear.
 *
 * Timing: every transfer has one setup and one access cycle, no wait.
 * Pass lines and the core request follow the request inputs by one cycle;
 * the interrupt line follows the sticky status by one more cycle.
 * Reset clears every register and output.
 *
 * Assumes request inputs synchronous to sys_clk and an APB master.
 */
// Summary of operation
// - no peripheral interrupt passes unless the global gate bit is set
// - second register bit 0 passes logic cell A request when one
// - third register bit 1 passes capture/compare B request when one
// - third register bit 0 passes capture/compare A request when one
`timescale 1ns/1ps
`include "pim_defines.vh"

module pim_top #(
    parameter AW = 8
) (
    input wire sys_clk,
    input wire rstn,
    input wire [AW-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire osc_fail_req,
    input wire clk_switch_done_req,
    input wire logic_cell_a_req,
    input wire logic_cell_b_req,
    input wire waveform_gen_req,
    input wire capcmp_a_req,
    input wire capcmp_b_req,
    output wire [15:0] periph_irq_pass,
    output wire core_periph_irq,
    output wire irq
);

    reg [7:0] periph_irq_enable_two_ff;
    reg [7:0] periph_irq_enable_three_ff;
    reg global_periph_irq_gate_ff;
    reg [31:0] prdata_ff;
    reg pslverr_ff;
    reg [15:0] pass_ff;
    reg core_irq_ff;
    reg irq_ff;

    reg [7:0] nxt_en_two;
    reg [7:0] nxt_en_three;
    reg nxt_gate;
    reg [31:0] nxt_prdata;
    reg nxt_pslverr;
    reg [15:0] nxt_pass;
    reg nxt_core_irq;
    reg nxt_irq;

    wire setup_cyc;
    wire commit;
    wire wr_commit;
    wire [15:0] req_vec;
    wire [15:0] en_vec;
    wire [15:0] status_vec;
    wire [15:0] clr_vec;
    wire [7:0] req_two;
    wire [7:0] req_three;
    wire [15:0] pending_vec;
    wire hit_en_two;
    wire hit_en_three;
    wire hit_core_ctrl;
    wire hit_status;
    wire hit_clear;
    wire hit_raw;

    // positions in the combined {third, second} vector
    localparam integer POS_LOGIC_CELL_A = `PIM_BIT_LOGIC_CELL_A;
    localparam integer POS_CAPCMP_B = 8 + `PIM_BIT_CAPCMP_B;
    localparam integer POS_CAPCMP_A = 8 + `PIM_BIT_CAPCMP_A;
    localparam [15:0] IMPL_MASK = {`PIM_MASK_EN_THREE, `PIM_MASK_EN_TWO};

    // offset match on the low address bits, upper bits must be zero
    function addr_hit;
        input [AW-1:0] addr;
        input [7:0] ofs;
        begin
            addr_hit = (addr[7:0] == ofs) && ((addr >> 8) == {AW{1'b0}});
        end
    endfunction

    // true for any offset that holds a register
    function addr_mapped;
        input [AW-1:0] addr;
        begin
            addr_mapped = addr_hit(addr, `PIM_OFS_EN_TWO)
                | addr_hit(addr, `PIM_OFS_EN_THREE)
                | addr_hit(addr, `PIM_OFS_CORE_CTRL)
                | addr_hit(addr, `PIM_OFS_STATUS)
                | addr_hit(addr, `PIM_OFS_CLEAR)
                | addr_hit(addr, `PIM_OFS_RAW);
        end
    endfunction

    // one source passes only with its enable and the global gate
    function src_pass;
        input gate;
        input req;
        input en;
        begin
            src_pass = gate & req & en;
        end
    endfunction

    // apb handshake
    pim_apb_if u_apb (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .psel(psel),
        .penable(penable),
        .pready_ff(pready),
        .setup_cyc(setup_cyc),
        .commit(commit)
    );

    // a write lands at the completing access edge
    assign wr_commit = commit & pwrite;

    // register decode of the current address
    assign hit_en_two = addr_hit(paddr, `PIM_OFS_EN_TWO);
    assign hit_en_three = addr_hit(paddr, `PIM_OFS_EN_THREE);
    assign hit_core_ctrl = addr_hit(paddr, `PIM_OFS_CORE_CTRL);
    assign hit_status = addr_hit(paddr, `PIM_OFS_STATUS);
    assign hit_clear = addr_hit(paddr, `PIM_OFS_CLEAR);
    assign hit_raw = addr_hit(paddr, `PIM_OFS_RAW);

    // request lines placed in enable-register layout
    assign req_two = {osc_fail_req, clk_switch_done_req, 4'h0,
        logic_cell_b_req, logic_cell_a_req};
    assign req_three = {1'b0, waveform_gen_req, 4'h0,
        capcmp_b_req, capcmp_a_req};
    // combined layout, third register in the upper byte
    assign req_vec = {req_three, req_two};
    assign en_vec = {periph_irq_enable_three_ff, periph_irq_enable_two_ff};

    // enabled sticky events waiting for service
    assign pending_vec = status_vec & en_vec;

    // write-one clear of the status bits, only implemented bits
    assign clr_vec = (wr_commit && hit_clear)
        ? (pwdata[15:0] & IMPL_MASK) : 16'h0000;

    // sticky event status
    pim_sticky #(
        .W(16)
    ) u_status (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .set_vec(req_vec),
        .clr_vec(clr_vec),
        .status(status_vec)
    );

    // register writes take effect at the completing edge
    always @* begin
        nxt_en_two = periph_irq_enable_two_ff;
        nxt_en_three = periph_irq_enable_three_ff;
        nxt_gate = global_periph_irq_gate_ff;
        if (wr_commit) begin
            // unimplemented enable bits are never stored
            if (hit_en_two) begin
                nxt_en_two = pwdata[7:0] & `PIM_MASK_EN_TWO;
            end
            if (hit_en_three) begin
                nxt_en_three = pwdata[7:0] & `PIM_MASK_EN_THREE;
            end
            // only the gate bit of the core control word is kept
            if (hit_core_ctrl) begin
                nxt_gate = pwdata[`PIM_BIT_GLOBAL_GATE];
            end
        end
    end

    // read data and error captured in the setup phase
    always @* begin
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (setup_cyc) begin
            nxt_prdata = 32'h00000000;
            nxt_pslverr = ~addr_mapped(paddr);
            if (!pwrite) begin
                // enable registers and the gate
                if (hit_en_two) begin
                    nxt_prdata = {24'h000000, periph_irq_enable_two_ff};
                end
                if (hit_en_three) begin
                    nxt_prdata = {24'h000000, periph_irq_enable_three_ff};
                end
                if (hit_core_ctrl) begin
                    nxt_prdata = {31'h00000000, global_periph_irq_gate_ff};
                end
                // status and raw levels; clear and unmapped read zero
                if (hit_status) begin
                    nxt_prdata = {16'h0000, status_vec};
                end
                if (hit_raw) begin
                    nxt_prdata = {16'h0000, req_vec};
                end
            end
        end else if (commit) begin
            // error stands only for the access phase
            nxt_pslverr = 1'b0;
        end
    end

    // per-source pass lines, each gated by its enable and the global gate
    always @* begin
        nxt_pass = 16'h0000;
        if (global_periph_irq_gate_ff) begin
            nxt_pass = req_vec & en_vec;
        end
        // logic cell a on bit 0 of the second register
        nxt_pass[POS_LOGIC_CELL_A] = src_pass(global_periph_irq_gate_ff,
            logic_cell_a_req, periph_irq_enable_two_ff[`PIM_BIT_LOGIC_CELL_A]);
        // capture/compare b on bit 1 of the third register
        nxt_pass[POS_CAPCMP_B] = src_pass(global_periph_irq_gate_ff,
            capcmp_b_req, periph_irq_enable_three_ff[`PIM_BIT_CAPCMP_B]);
        // capture/compare a on bit 0 of the third register
        nxt_pass[POS_CAPCMP_A] = src_pass(global_periph_irq_gate_ff,
            capcmp_a_req, periph_irq_enable_three_ff[`PIM_BIT_CAPCMP_A]);
    end

    // live request to the core and sticky interrupt line
    always @* begin
        nxt_core_irq = |nxt_pass;
        nxt_irq = global_periph_irq_gate_ff & (|pending_vec);
    end

    // enable registers and global gate
    always @(posedge sys_clk) begin
        if (!rstn) begin
            periph_irq_enable_two_ff <= `PIM_RST_EN_TWO;
            periph_irq_enable_three_ff <= `PIM_RST_EN_THREE;
            global_periph_irq_gate_ff <= `PIM_RST_GLOBAL_GATE;
        end else begin
            periph_irq_enable_two_ff <= nxt_en_two;
            periph_irq_enable_three_ff <= nxt_en_three;
            global_periph_irq_gate_ff <= nxt_gate;
        end
    end

    // bus response
    always @(posedge sys_clk) begin
        if (!rstn) begin
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // interrupt outputs
    always @(posedge sys_clk) begin
        if (!rstn) begin
            pass_ff <= 16'h0000;
            core_irq_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            pass_ff <= nxt_pass;
            core_irq_ff <= nxt_core_irq;
            irq_ff <= nxt_irq;
        end
    end

    // bus outputs straight from flops
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;

    // interrupt outputs straight from flops
    assign periph_irq_pass = pass_ff;
    assign core_periph_irq = core_irq_ff;
    assign irq = irq_ff;

endmodule

// ==== design/pim_defines.vh ====
/*
 * Constants for the peripheral interrupt enable mask block:
 * register byte offsets, field positions, writable masks and reset values.
 * Assumes a 32-bit APB register bus with word-aligned registers.
 */
`ifndef PIM_DEFINES_VH
`define PIM_DEFINES_VH

// register byte offsets
`define PIM_OFS_EN_TWO 8'h00
`define PIM_OFS_EN_THREE 8'h04
`define PIM_OFS_CORE_CTRL 8'h08
`define PIM_OFS_STATUS 8'h0C
`define PIM_OFS_CLEAR 8'h10
`define PIM_OFS_RAW 8'h14

// bit positions in the second enable register
`define PIM_BIT_OSC_FAIL 7
`define PIM_BIT_CLK_SWITCH 6
`define PIM_BIT_LOGIC_CELL_B 1
`define PIM_BIT_LOGIC_CELL_A 0

// bit positions in the third enable register
`define PIM_BIT_WAVEFORM_GEN 6
`define PIM_BIT_CAPCMP_B 1
`define PIM_BIT_CAPCMP_A 0

// bit position of the global gate in the core control register
`define PIM_BIT_GLOBAL_GATE 0

// implemented bits, all others read as zero
`define PIM_MASK_EN_TWO 8'hC3
`define PIM_MASK_EN_THREE 8'h43

// reset values
`define PIM_RST_EN_TWO 8'h00
`define PIM_RST_EN_THREE 8'h00
`define PIM_RST_GLOBAL_GATE 1'b0

`endif

// ==== design/pim_apb_if.v ====
/*
 * APB handshake for the mask block: one wait-free access phase.
 * Assumes an APB master that holds the request until pready is seen high.
 */
`timescale 1ns/1ps

module pim_apb_if (
    input wire sys_clk,
    input wire rstn,
    input wire psel,
    input wire penable,
    output reg pready_ff,
    output wire setup_cyc,
    output wire commit
);

    reg nxt_pready;

    // setup phase and completing access edge
    assign setup_cyc = psel & ~penable;
    assign commit = psel & penable & pready_ff;

    // ready rises for the access phase, falls after completion
    always @* begin
        nxt_pready = pready_ff;
        if (commit) begin
            nxt_pready = 1'b0;
        end else if (setup_cyc) begin
            nxt_pready = 1'b1;
        end
    end

    // ready flop
    always @(posedge sys_clk) begin
        if (!rstn) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= nxt_pready;
        end
    end

endmodule

// ==== design/pim_sticky.v ====
/*
 * Sticky event bits: set by hardware, cleared by software write-one.
 * Assumes set and clear vectors synchronous to sys_clk.
 */
`timescale 1ns/1ps

module pim_sticky #(
    parameter W = 16
) (
    input wire sys_clk,
    input wire rstn,
    input wire [W-1:0] set_vec,
    input wire [W-1:0] clr_vec,
    output wire [W-1:0] status
);

    // one flop per bit; a set in the clear cycle wins
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg bit_ff;
            always @(posedge sys_clk) begin
                if (!rstn) begin
                    bit_ff <= 1'b0;
                end else if (set_vec[i]) begin
                    bit_ff <= 1'b1;
                end else if (clr_vec[i]) begin
                    bit_ff <= 1'b0;
                end
            end
            assign status[i] = bit_ff;
        end
    endgenerate

endmodule

// ==== tb/pim_checker.sv ====
/* port checker for the interrupt mask block.
   assumes one sys_clk domain, rstn synchronous active low, bound in tb. */
`timescale 1ns/1ps
`include "pim_defines.vh"
module pim_checker #(parameter AW = 8) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic osc_fail_req,
    input wire logic logic_cell_a_req,
    input wire logic capcmp_a_req,
    input wire logic capcmp_b_req,
    input wire logic [15:0] periph_irq_pass,
    input wire logic core_periph_irq,
    input wire logic irq
);
    logic gate_ff;
    logic [7:0] en_two_ff;
    logic [7:0] en_three_ff;
    wire wr_done = psel && penable && pready && pwrite;

    // shadow of the bus-written gate and enables
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            gate_ff <= 1'b0;
            en_two_ff <= 8'h00;
            en_three_ff <= 8'h00;
        end else if (wr_done) begin
            if (paddr == `PIM_OFS_CORE_CTRL) gate_ff <= pwdata[0];
            if (paddr == `PIM_OFS_EN_TWO) en_two_ff <= pwdata[7:0];
            if (paddr == `PIM_OFS_EN_THREE) en_three_ff <= pwdata[7:0];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // gating of the oscillator fail, logic cell a and capture/compare a and b sources, plus the core or, unused bits and ready
    property p_gate_blocks; !gate_ff |=> periph_irq_pass == 16'h0000 && !irq; endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("pass without gate");
    property p_core_or; core_periph_irq == (|periph_irq_pass); endproperty
    a_core_or: assert property (p_core_or) else $error("core request not the or");
    property p_cell_a; gate_ff && en_two_ff[0] && logic_cell_a_req |=> periph_irq_pass[0]; endproperty
    a_cell_a: assert property (p_cell_a) else $error("cell a not passed");
    property p_cell_a_off; !en_two_ff[0] |=> !periph_irq_pass[0]; endproperty
    a_cell_a_off: assert property (p_cell_a_off) else $error("cell a not blocked");
    property p_capcmp_b; gate_ff && en_three_ff[1] |=> periph_irq_pass[9] == $past(capcmp_b_req); endproperty
    a_capcmp_b: assert property (p_capcmp_b) else $error("capcmp b wrong");
    property p_capcmp_a; !en_three_ff[0] || !capcmp_a_req |=> !periph_irq_pass[8]; endproperty
    a_capcmp_a: assert property (p_capcmp_a) else $error("capcmp a not blocked");
    property p_osc; gate_ff && en_two_ff[7] && osc_fail_req |=> periph_irq_pass[7]; endproperty
    a_osc: assert property (p_osc) else $error("osc fail not passed");
    property p_unimpl; (periph_irq_pass & 16'hBC3C) == 16'h0000; endproperty
    a_unimpl: assert property (p_unimpl) else $error("unused bit passed");
    property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
    a_ready: assert property (p_ready) else $error("ready not one cycle");

    c_core: cover property (core_periph_irq);
    c_irq: cover property ($rose(irq));
    c_shut: cover property (!gate_ff && capcmp_b_req);
endmodule

// ==== tb/tb.sv ====
/* self-checking bench for the mask block over apb.
   assumes the design header on the include path. */
`timescale 1ns/1ps
`include "pim_defines.vh"
module tb;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [6:0] rq = 7'h00;
    wire [31:0] prdata;
    wire pready, pslverr, core_periph_irq, irq;
    wire [15:0] periph_irq_pass;
    logic [31:0] rd;
    logic err;
    logic [15:0] e;
    int mismatches = 0;
    int num_checks = 0;
    int pos[7] = '{7, 6, 1, 0, 14, 9, 8};

    always #12.5 sys_clk = ~sys_clk;

    pim_top pim_top_inst (.sys_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .osc_fail_req(rq[0]), .clk_switch_done_req(rq[1]), .logic_cell_b_req(rq[2]),
        .logic_cell_a_req(rq[3]), .waveform_gen_req(rq[4]), .capcmp_b_req(rq[5]), .capcmp_a_req(rq[6]),
        .periph_irq_pass, .core_periph_irq, .irq);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one apb transfer, held until pready is sampled
    task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // wait for ready; only the watchdog ends a hung transfer
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (4000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish;
    end

    initial begin
        w(12);
        rstn <= 1'b1;
        w(1);
        rdc(`PIM_OFS_EN_TWO, 32'h0);
        rdc(`PIM_OFS_EN_THREE, 32'h0);
        rdc(`PIM_OFS_CORE_CTRL, 32'h0);
        wr(`PIM_OFS_EN_TWO, 32'hFFFFFFFF);
        rdc(`PIM_OFS_EN_TWO, 32'hC3);
        wr(`PIM_OFS_EN_THREE, 32'hFFFFFFFF);
        rdc(`PIM_OFS_EN_THREE, 32'h43);
        // all sources raised with the gate shut
        rq <= 7'h7F;
        w(2);
        chk(periph_irq_pass, 32'h0);
        chk(irq, 32'h0);
        rdc(`PIM_OFS_STATUS, 32'h43C3);
        wr(`PIM_OFS_CORE_CTRL, 32'h1);
        w(1);
        chk(periph_irq_pass, 32'h43C3);
        chk(core_periph_irq, 32'h1);
        // each source alone: passed, then masked
        for (int i = 0; i < 7; i++) begin
            e = 16'h1 << pos[i];
            rq <= 7'h01 << i;
            wr(`PIM_OFS_EN_TWO, {24'h0, e[7:0]});
            wr(`PIM_OFS_EN_THREE, {24'h0, e[15:8]});
            w(1);
            chk(periph_irq_pass, {16'h0, e});
            rdc(`PIM_OFS_RAW, {16'h0, e});
            wr(`PIM_OFS_EN_TWO, 32'h0);
            wr(`PIM_OFS_EN_THREE, 32'h0);
            w(1);
            chk(periph_irq_pass, 32'h0);
        end
        // sticky event, masked, unmasked, cleared
        rq <= 7'h00;
        wr(`PIM_OFS_EN_THREE, 32'h2);
        wr(`PIM_OFS_CLEAR, 32'hFFFF);
        w(1);
        chk(irq, 32'h0);
        rq <= 7'h20;
        w(1);
        rq <= 7'h00;
        w(2);
        chk(irq, 32'h1);
        rdc(`PIM_OFS_STATUS, 32'h0200);
        wr(`PIM_OFS_EN_THREE, 32'h0);
        w(1);
        chk(irq, 32'h0);
        wr(`PIM_OFS_EN_THREE, 32'h2);
        w(1);
        chk(irq, 32'h1);
        wr(`PIM_OFS_CORE_CTRL, 32'h0);
        w(1);
        chk(irq, 32'h0);
        wr(`PIM_OFS_CLEAR, 32'h0200);
        rdc(`PIM_OFS_STATUS, 32'h0);
        // status ignores writes, clear reads zero without error
        wr(`PIM_OFS_STATUS, 32'hFFFF);
        rdc(`PIM_OFS_STATUS, 32'h0);
        rdc(`PIM_OFS_CLEAR, 32'h0);
        chk(err, 32'h0);
        // unmapped place
        wr(8'h20, 32'hFF);
        chk(err, 32'h1);
        rdc(8'h20, 32'h0);
        chk(err, 32'h1);
        tally_and_finish;
    end
endmodule

bind pim_top pim_checker #(.AW(AW)) pim_checker_inst (.sys_clk, .rstn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pready, .osc_fail_req, .logic_cell_a_req, .capcmp_a_req, .capcmp_b_req, .periph_irq_pass,
    .core_periph_irq, .irq);
